// ==== hdl/ip_classifier_match.sv ====
`timescale 1ns/100ps
`default_nettype none
module ip_classifier_match #(
   parameter int         ENTRIES  = 4,
   parameter logic [7:0] ERR_CODE = 8'h01
) (
   // Clock and reset.
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Classifier set-up octet stream.
   input  wire logic                 cfg_start,
   input  wire logic [7:0]           cfg_idx,
   input  wire logic [7:0]           cfg_prio,
   input  wire logic                 cfg_valid,
   input  wire logic [7:0]           cfg_octet,
   input  wire logic                 cfg_last,
   // Set-up response.
   output logic                      resp_valid,
   output logic                      resp_ok,
   output logic                      resp_drop_enc,
   output ip_cls_pkg::err_set_s      resp_err,
   // Packet path.
   input  wire logic                 pkt_valid,
   input  wire ip_cls_pkg::pkt_hdr_s pkt_hdr,
   output logic                      match_valid,
   output logic                      match_hit,
   output logic [7:0]                match_idx
);
   import ip_cls_pkg::*;

   localparam int IW = $clog2(ENTRIES);

   // The index ports are eight bits and a zero code would read as success.
   if (ENTRIES < 2 || ENTRIES > 256) begin : g_bad_entries
      $error("ENTRIES must be 2 to 256");
   end
   if (ERR_CODE == 8'h00) begin : g_bad_code
      $error("ERR_CODE must be non-zero");
   end

   typedef enum logic [1:0] {P_IDLE, P_TYPE, P_LEN, P_VAL} parse_e;

   parse_e      state;
   cls_cfg_s    ent [ENTRIES];
   cls_cfg_s    work;
   logic [IW-1:0] idx;
   logic [7:0]  sub;
   logic [7:0]  left;
   logic [31:0] val;
   logic [8:0]  octs;
   logic        done;
   logic        err;
   err_set_s    err_set;
   logic [31:0] next_val;
   logic [7:0]  want_len;
   logic        fault;
   err_set_s    fault_set;
   logic        busy_take;

   assign busy_take = cfg_valid && !cfg_start && state != P_IDLE;
   assign next_val  = {val[23:0], cfg_octet};

   // Expected value length for each known sub-type; zero marks unknown.
   always_comb begin
      case (sub)
         SUB_TOS:   want_len = TOS_LEN;
         SUB_PROT:  want_len = PROT_LEN;
         SUB_SRC, SUB_SMASK, SUB_DST, SUB_DMASK: want_len = ADDR_LEN;
         SUB_SPLO, SUB_SPHI, SUB_DPLO, SUB_DPHI: want_len = PORT_LEN;
         default:   want_len = 8'h00;
      endcase
   end

   // Fault detection for the octet taken this cycle.
   always_comb begin
      fault = 1'b0;
      fault_set = '{plen: EP_TWO, param: {IP_ENC_TYPE, sub}, code: ERR_CODE};
      if (busy_take) begin
         if (octs == ENC_LIMIT - 9'h001) begin
            fault = 1'b1;
            fault_set.plen = EP_ONE;
            fault_set.param = {8'h00, IP_ENC_TYPE};
         end else if (state == P_TYPE && cfg_last) begin
            fault = 1'b1;
            fault_set.param = {IP_ENC_TYPE, cfg_octet};
         end else if (state == P_LEN
                      && (want_len == 8'h00 || cfg_octet != want_len || cfg_last)) begin
            fault = 1'b1;
         end else if (state == P_VAL && cfg_last && left != 8'h01) begin
            fault = 1'b1;
         end else if (state == P_VAL && left == 8'h01 && sub == SUB_PROT
                      && next_val[15:0] > PROT_TCPUDP) begin
            fault = 1'b1;
         end
      end
   end

   // Parser state, octet count and end-of-encoding strobe.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= P_IDLE;
         sub   <= 8'h00;
         left  <= 8'h00;
         val   <= 32'h0;
         octs  <= 9'h000;
         done  <= 1'b0;
         idx   <= '0;
      end else begin
         done <= 1'b0;
         if (cfg_start) begin
            state <= P_TYPE;
            octs  <= 9'h000;
            idx   <= IW'(cfg_idx);
         end else if (busy_take) begin
            octs <= octs + 9'h001;
            case (state)
               P_TYPE: begin
                  sub   <= cfg_octet;
                  state <= P_LEN;
               end
               P_LEN: begin
                  left  <= cfg_octet;
                  val   <= 32'h0;
                  state <= (cfg_octet == 8'h00) ? P_TYPE : P_VAL;
               end
               P_VAL: begin
                  val  <= next_val;
                  left <= left - 8'h01;
                  if (left == 8'h01) begin
                     state <= P_TYPE;
                  end
               end
               default: state <= P_IDLE;
            endcase
            if (cfg_last) begin
               state <= P_IDLE;
               done  <= 1'b1;
            end
         end
      end
   end

   // First fault of an encoding is kept; later ones are ignored, even when their error set differs.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         err     <= 1'b0;
         err_set <= '0;
      end else if (cfg_start) begin
         err     <= 1'b0;
         err_set <= '0;
      end else if (fault && !err) begin
         err     <= 1'b1;
         err_set <= fault_set;
      end
   end

   // Working copy: absent parameters keep the defaults loaded at start.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         work <= CFG_DEFAULT;
      end else if (cfg_start) begin
         work      <= CFG_DEFAULT;
         work.prio <= cfg_prio;
      end else if (busy_take && state == P_VAL && left == 8'h01) begin
         case (sub)
            SUB_TOS: begin
               work.has_tos  <= 1'b1;
               work.tos_lo   <= next_val[23:16];
               work.tos_hi   <= next_val[15:8];
               work.tos_mask <= next_val[7:0];
            end
            SUB_PROT: begin
               work.has_prot <= 1'b1;
               work.prot     <= next_val[15:0];
            end
            SUB_SRC: begin
               work.has_src <= 1'b1;
               work.src     <= next_val;
            end
            SUB_SMASK: work.smask <= next_val;
            SUB_DST: begin
               work.has_dst <= 1'b1;
               work.dst     <= next_val;
            end
            SUB_DMASK: work.dmask <= next_val;
            SUB_SPLO:  work.sp_lo <= next_val[15:0];
            SUB_SPHI:  work.sp_hi <= next_val[15:0];
            SUB_DPLO:  work.dp_lo <= next_val[15:0];
            SUB_DPHI:  work.dp_hi <= next_val[15:0];
            default:   work.valid <= 1'b0;
         endcase
      end
   end

   // Entry table; a rejected encoding leaves its slot unable to match.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < ENTRIES; i++) begin
            ent[i] <= CFG_DEFAULT;
         end
      end else if (done) begin
         ent[idx]       <= work;
         ent[idx].valid <= !err;
      end
   end

   // Response: error set only for a rejected encoding.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid    <= 1'b0;
         resp_ok       <= 1'b0;
         resp_drop_enc <= 1'b0;
         resp_err      <= '0;
      end else begin
         resp_valid <= done;
         if (done) begin
            resp_ok       <= !err;
            resp_drop_enc <= err;
            resp_err      <= err ? err_set : '0;
         end
      end
   end

   // Per-entry comparisons, one copy per table slot.
   logic [ENTRIES-1:0] tos_ok;
   logic [ENTRIES-1:0] prot_ok;
   logic [ENTRIES-1:0] src_ok;
   logic [ENTRIES-1:0] dst_ok;
   logic [ENTRIES-1:0] port_ok;
   logic [ENTRIES-1:0] hit;
   logic               is_l4;

   assign is_l4 = pkt_hdr.proto == PROT_TCP || pkt_hdr.proto == PROT_UDP;

   for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
      logic [7:0] tosm;
      assign tosm = pkt_hdr.tos & ent[g].tos_mask;
      assign tos_ok[g] = !ent[g].has_tos ||
         (tosm >= ent[g].tos_lo && tosm <= ent[g].tos_hi);
      assign prot_ok[g] = !ent[g].has_prot || ent[g].prot == PROT_ANY ||
         (ent[g].prot == PROT_TCPUDP && is_l4) ||
         ent[g].prot == {8'h00, pkt_hdr.proto};
      assign src_ok[g] = !ent[g].has_src ||
         (pkt_hdr.src & ent[g].smask) == ent[g].src;
      assign dst_ok[g] = !ent[g].has_dst ||
         (pkt_hdr.dst & ent[g].dmask) == ent[g].dst;
      // Ports sit only in TCP and UDP headers, so other traffic skips them.
      assign port_ok[g] = !is_l4 ||
         (pkt_hdr.sport >= ent[g].sp_lo && pkt_hdr.sport <= ent[g].sp_hi &&
          pkt_hdr.dport >= ent[g].dp_lo && pkt_hdr.dport <= ent[g].dp_hi);
      assign hit[g] = ent[g].valid && tos_ok[g] && prot_ok[g] &&
         src_ok[g] && dst_ok[g] && port_ok[g];
   end

   // Highest priority wins; equal priorities go to the lower slot.
   logic          best_hit;
   logic [IW-1:0] best_idx;
   logic [7:0]    best_prio;
   always_comb begin
      best_hit  = 1'b0;
      best_idx  = '0;
      best_prio = 8'h00;
      for (int i = 0; i < ENTRIES; i++) begin
         if (hit[i] && (!best_hit || ent[i].prio > best_prio)) begin
            best_hit  = 1'b1;
            best_idx  = IW'(i);
            best_prio = ent[i].prio;
         end
      end
   end

   // Match result, one cycle after the header is presented.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_valid <= 1'b0;
         match_hit   <= 1'b0;
         match_idx   <= 8'h00;
      end else begin
         match_valid <= pkt_valid;
         if (pkt_valid) begin
            match_hit <= best_hit;
            match_idx <= 8'(best_idx);
         end
      end
   end

   // Checks.
   sequence s_enc_end;
      busy_take && cfg_last;
   endsequence

   sequence s_resp_pulse;
      resp_valid ##1 !resp_valid;
   endsequence

   a_tos_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ent[0].has_tos && ((pkt_hdr.tos & ent[0].tos_mask) > ent[0].tos_hi) |-> !hit[0])
      else $error("ToS above window matched");
   a_tos_absent: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ent[0].valid && !ent[0].has_tos && !ent[0].has_src && !ent[0].has_dst
      && ent[0].prot == {8'h00, pkt_hdr.proto} && {ent[0].sp_lo, ent[0].dp_lo} == 32'h0
      && {ent[0].sp_hi, ent[0].dp_hi} == 32'hffffffff |-> hit[0])
      else $error("absent ToS blocked a match");
   a_prot_any: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ent[3].valid && ent[3].has_prot && ent[3].prot == PROT_ANY && !ent[3].has_tos
      && !ent[3].has_src && !ent[3].has_dst && !is_l4 |-> hit[3])
      else $error("wildcard protocol failed");
   a_prot_bad: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busy_take && state == P_VAL && left == 8'h01 && sub == SUB_PROT
      && next_val[15:0] > PROT_TCPUDP ##0 s_enc_end |=> ##1 !ent[idx].valid && !resp_ok)
      else $error("bad protocol entry left valid");
   a_src_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ent[1].has_src && (pkt_hdr.src & ent[1].smask) != ent[1].src |-> !hit[1])
      else $error("source mismatch matched");
   a_port_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ent[3].valid && !is_l4 && tos_ok[3] && prot_ok[3]
      && src_ok[3] && dst_ok[3] |-> hit[3])
      else $error("ports used for non TCP/UDP");
   a_resp_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_enc_end |=> ##1 s_resp_pulse)
      else $error("response not a single pulse");
   a_ok_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
      resp_valid && resp_ok |-> resp_err == '0 && !resp_drop_enc)
      else $error("success carries error set");
   a_err_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
      resp_valid && !resp_ok |-> resp_err.code == ERR_CODE && resp_drop_enc)
      else $error("error set code wrong");
   a_match_lat: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pkt_valid |=> match_valid && match_hit == $past(|hit))
      else $error("match result late or wrong");
   a_prio_pick: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pkt_valid && hit[0] && hit[1] && ent[1].prio > ent[0].prio |=> match_idx != 8'h00)
      else $error("lower priority entry chosen");

endmodule
`default_nettype wire

// ==== hdl/ip_cls_pkg.sv ====
`default_nettype none
package ip_cls_pkg;

   // Sub-type codes inside the IP classification encoding.
   localparam logic [7:0] IP_ENC_TYPE = 8'h09;
   localparam logic [7:0] SUB_TOS     = 8'h01;
   localparam logic [7:0] SUB_PROT    = 8'h02;
   localparam logic [7:0] SUB_SRC     = 8'h03;
   localparam logic [7:0] SUB_SMASK   = 8'h04;
   localparam logic [7:0] SUB_DST     = 8'h05;
   localparam logic [7:0] SUB_DMASK   = 8'h06;
   localparam logic [7:0] SUB_SPLO    = 8'h07;
   localparam logic [7:0] SUB_SPHI    = 8'h08;
   localparam logic [7:0] SUB_DPLO    = 8'h09;
   localparam logic [7:0] SUB_DPHI    = 8'h0a;

   // Value lengths in octets.
   localparam logic [7:0] TOS_LEN  = 8'h03;
   localparam logic [7:0] PROT_LEN = 8'h02;
   localparam logic [7:0] ADDR_LEN = 8'h04;
   localparam logic [7:0] PORT_LEN = 8'h02;

   // Protocol codes.
   localparam logic [15:0] PROT_ANY    = 16'h0100;
   localparam logic [15:0] PROT_TCPUDP = 16'h0101;
   localparam logic [7:0]  PROT_TCP    = 8'h06;
   localparam logic [7:0]  PROT_UDP    = 8'h11;

   // Whole encoding must stay below this many octets.
   localparam logic [8:0] ENC_LIMIT = 9'h100;

   // Errored parameter lengths.
   localparam logic [1:0] EP_ONE = 2'h1;
   localparam logic [1:0] EP_TWO = 2'h2;

   typedef struct packed {
      logic        valid;
      logic [7:0]  prio;
      logic        has_tos;
      logic [7:0]  tos_lo;
      logic [7:0]  tos_hi;
      logic [7:0]  tos_mask;
      logic        has_prot;
      logic [15:0] prot;
      logic        has_src;
      logic [31:0] src;
      logic [31:0] smask;
      logic        has_dst;
      logic [31:0] dst;
      logic [31:0] dmask;
      logic [15:0] sp_lo;
      logic [15:0] sp_hi;
      logic [15:0] dp_lo;
      logic [15:0] dp_hi;
   } cls_cfg_s;

   // Reset and start value of an entry: full address masks, zero ToS mask and full port ranges.
   localparam cls_cfg_s CFG_DEFAULT = '{smask: 32'hffffffff, dmask: 32'hffffffff,
      sp_hi: 16'hffff, dp_hi: 16'hffff, default: '0};

   typedef struct packed {
      logic [7:0]  tos;
      logic [7:0]  proto;
      logic [31:0] src;
      logic [31:0] dst;
      logic [15:0] sport;
      logic [15:0] dport;
   } pkt_hdr_s;

   typedef struct packed {
      logic [1:0]  plen;
      logic [15:0] param;
      logic [7:0]  code;
   } err_set_s;

endpackage
`default_nettype wire

// ==== verification/cls_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Signalling peer that hands classifier set-up encodings to the block.
module cls_peer (
   // Clock.
   input  wire logic  ref_clk,
   // Set-up stream towards the block.
   output logic       cfg_start,
   output logic [7:0] cfg_idx,
   output logic [7:0] cfg_prio,
   output logic       cfg_valid,
   output logic [7:0] cfg_octet,
   output logic       cfg_last
);
   // Idle levels from time zero, so the block never sees an undriven stream.
   initial begin
      cfg_start = 1'b0;
      cfg_idx   = 8'h00;
      cfg_prio  = 8'h00;
      cfg_valid = 1'b0;
      cfg_octet = 8'h00;
      cfg_last  = 1'b0;
   end

   // Sends one encoding whose values are already laid out most significant octet first.
   // Only request content is ever sent, never an error set.
   // A non-zero gap idles the strobe between octets, and the octet lines toggle meanwhile
   // so that a stale value can never be taken by mistake.
   task automatic send(input logic [7:0] idx, input logic [7:0] prio,
                       input logic [7:0] b[$], input int gap);
      @(negedge ref_clk);
      cfg_start = 1'b1;
      cfg_idx   = idx;
      cfg_prio  = prio;
      @(negedge ref_clk);
      cfg_start = 1'b0;
      cfg_idx   = ~idx;
      cfg_prio  = ~prio;
      foreach (b[i]) begin
         cfg_valid = 1'b1;
         cfg_octet = b[i];
         cfg_last  = (i == b.size() - 1);
         @(negedge ref_clk);
         repeat (gap) begin
            cfg_valid = 1'b0;
            cfg_last  = 1'b0;
            cfg_octet = ~cfg_octet;
            @(negedge ref_clk);
         end
      end
      cfg_valid = 1'b0;
      cfg_last  = 1'b0;
      cfg_octet = ~cfg_octet;
   endtask
endmodule
`default_nettype wire

// ==== verification/ip_classifier_match_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module ip_classifier_match_test;
   import ip_cls_pkg::*;
   localparam logic [7:0] ERR = 8'h01;
   logic        ref_clk;
   logic        rst_n;
   logic        cfg_start;
   logic [7:0]  cfg_idx;
   logic [7:0]  cfg_prio;
   logic        cfg_valid;
   logic [7:0]  cfg_octet;
   logic        cfg_last;
   logic        resp_valid;
   logic        resp_ok;
   logic        resp_drop_enc;
   err_set_s    resp_err;
   logic        pkt_valid;
   pkt_hdr_s    pkt_hdr;
   logic        match_valid;
   logic        match_hit;
   logic [7:0]  match_idx;
   logic [7:0]  q[$];
   int          n_fail;
   int          checks_done;

   // Free-running 50 MHz clock.
   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;

   cls_peer peer (.ref_clk(ref_clk), .cfg_start(cfg_start), .cfg_idx(cfg_idx),
      .cfg_prio(cfg_prio), .cfg_valid(cfg_valid), .cfg_octet(cfg_octet), .cfg_last(cfg_last));

   ip_classifier_match #(.ENTRIES(4), .ERR_CODE(ERR)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .cfg_start(cfg_start), .cfg_idx(cfg_idx), .cfg_prio(cfg_prio), .cfg_valid(cfg_valid),
      .cfg_octet(cfg_octet), .cfg_last(cfg_last), .resp_valid(resp_valid), .resp_ok(resp_ok),
      .resp_drop_enc(resp_drop_enc), .resp_err(resp_err), .pkt_valid(pkt_valid),
      .pkt_hdr(pkt_hdr), .match_valid(match_valid), .match_hit(match_hit),
      .match_idx(match_idx));

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Compares the response word: valid, ok, drop flag and error set.
   task automatic chk_rsp(input logic [28:0] exp);
      logic [28:0] got;
      got = {resp_valid, resp_ok, resp_drop_enc, resp_err};
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t rsp got %h exp %h", $time, got, exp);
      end
   endtask

   // Compares a match result; the slot is only meaningful on a hit.
   task automatic chk_pkt(input logic eh, input logic [7:0] ei);
      logic [9:0] got;
      got = {match_valid, match_hit, eh ? match_idx : 8'h00};
      checks_done++;
      if (got !== {1'b1, eh, eh ? ei : 8'h00}) begin
         n_fail++;
         $display("BAD %0t pkt got %h exp %h", $time, got, {1'b1, eh, eh ? ei : 8'h00});
      end
   endtask

   // Sends an encoding, waits a bounded time for the response and checks it.
   task automatic cfg(input logic [7:0] idx, input logic [7:0] prio, input int gap,
                      input logic [28:0] exp);
      int n;
      peer.send(idx, prio, q, gap);
      n = 0;
      while (resp_valid !== 1'b1 && n < 6) begin
         @(negedge ref_clk);
         n++;
      end
      chk_rsp(exp);
   endtask

   // Presents one header for one cycle and checks the answer the cycle after.
   task automatic pk(input logic [7:0] t, input logic [7:0] p, input logic [31:0] s,
                     input logic [31:0] d, input logic [15:0] sp, input logic [15:0] dp,
                     input logic eh, input logic [7:0] ei);
      @(negedge ref_clk);
      pkt_valid = 1'b1;
      pkt_hdr   = '{tos: t, proto: p, src: s, dst: d, sport: sp, dport: dp};
      @(negedge ref_clk);
      pkt_valid = 1'b0;
      pkt_hdr   = ~pkt_hdr;
      chk_pkt(eh, ei);
   endtask

   // A hang must still end in a verdict.
   initial begin
      #200us;
      n_fail++;
      test_done();
   end

   // Main sequence.
   initial begin
      rst_n     = 1'b0;
      pkt_valid = 1'b0;
      pkt_hdr   = '0;
      repeat (3) @(negedge ref_clk);
      chk_rsp(29'h0);
      rst_n = 1'b1;
      // Slot 0 matches TCP only; slot 1 ToS range and source subnet, sent slowly.
      q = '{8'h02, 8'h02, 8'h00, 8'h06};
      cfg(8'h00, 8'h05, 0, {3'b110, 26'h0});
      q = '{8'h01, 8'h03, 8'h10, 8'h20, 8'hfc, 8'h03, 8'h04, 8'h0a, 8'h00, 8'h00, 8'h00,
            8'h04, 8'h04, 8'hff, 8'h00, 8'h00, 8'h00};
      cfg(8'h01, 8'h09, 1, {3'b110, 26'h0});
      // Slot 2 exact destination, TCP or UDP, source ports 100..200.
      q = '{8'h05, 8'h04, 8'hc0, 8'ha8, 8'h00, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01,
            8'h07, 8'h02, 8'h00, 8'h64, 8'h08, 8'h02, 8'h00, 8'hc8};
      cfg(8'h02, 8'h07, 0, {3'b110, 26'h0});
      // Slot 3 any protocol, destination ports up to 80 with the low bound left out.
      q = '{8'h02, 8'h02, 8'h01, 8'h00, 8'h0a, 8'h02, 8'h00, 8'h50};
      cfg(8'h03, 8'h08, 0, {3'b110, 26'h0});
      pk(8'h00, 8'h06, 32'h01010101, 32'h02020202, 16'd0, 16'd1000, 1'b1, 8'h00);
      pk(8'h00, 8'h11, 32'h01010101, 32'h02020202, 16'd0, 16'd1000, 1'b0, 8'h00);
      pk(8'h13, 8'h11, 32'h0a010203, 32'h0, 16'd0, 16'd1000, 1'b1, 8'h01);
      pk(8'h57, 8'h06, 32'h0a010203, 32'h0, 16'd0, 16'd1000, 1'b1, 8'h00);
      pk(8'h13, 8'h11, 32'h0b010203, 32'h0, 16'd0, 16'd1000, 1'b0, 8'h00);
      pk(8'h13, 8'h06, 32'h0a010203, 32'h0, 16'd0, 16'd1000, 1'b1, 8'h01);
      pk(8'h00, 8'h11, 32'h0, 32'hc0a80001, 16'd150, 16'd1000, 1'b1, 8'h02);
      pk(8'h00, 8'h06, 32'h1, 32'hc0a80001, 16'd100, 16'd1000, 1'b1, 8'h02);
      pk(8'h00, 8'h11, 32'h0, 32'hc0a80001, 16'd200, 16'd1000, 1'b1, 8'h02);
      pk(8'h00, 8'h11, 32'h0, 32'hc0a80001, 16'd201, 16'd1000, 1'b0, 8'h00);
      pk(8'h00, 8'h11, 32'h0, 32'hc0a80001, 16'd99, 16'd1000, 1'b0, 8'h00);
      pk(8'h00, 8'h11, 32'h0, 32'hc0a80002, 16'd150, 16'd1000, 1'b0, 8'h00);
      pk(8'h00, 8'h01, 32'h0, 32'hc0a80001, 16'd150, 16'd1000, 1'b1, 8'h03);
      pk(8'h00, 8'h11, 32'h0, 32'h0, 16'd0, 16'd80, 1'b1, 8'h03);
      pk(8'h00, 8'h11, 32'h0, 32'h0, 16'd0, 16'd81, 1'b0, 8'h00);
      pk(8'h00, 8'h06, 32'h0, 32'h0, 16'd0, 16'd81, 1'b1, 8'h00);
      // Protocol 258 is refused, and the slot it lands in can no longer match.
      q = '{8'h02, 8'h02, 8'h01, 8'h02};
      cfg(8'h03, 8'h0a, 0, {3'b101, EP_TWO, 16'h0902, ERR});
      pk(8'h00, 8'h01, 32'h0, 32'h0, 16'd0, 16'd10, 1'b0, 8'h00);
      // An accepted encoding after a refusal carries no error set again.
      q = '{8'h02, 8'h02, 8'h01, 8'h00};
      cfg(8'h03, 8'h02, 0, {3'b110, 26'h0});
      pk(8'h00, 8'h01, 32'h0, 32'h0, 16'd0, 16'd10, 1'b1, 8'h03);
      // Unknown sub-type names the two-level path in error.
      q = '{8'h0b, 8'h02, 8'h00, 8'h00};
      cfg(8'h03, 8'h02, 0, {3'b101, EP_TWO, 16'h090b, ERR});
      // A 256-octet encoding is too long and names the one-level type.
      q = {};
      repeat (51) q = {q, 8'h01, 8'h03, 8'h00, 8'hff, 8'hff};
      q.push_back(8'h01);
      cfg(8'h00, 8'h05, 0, {3'b101, EP_ONE, 16'h0009, ERR});
      pk(8'h00, 8'h06, 32'h0, 32'h0, 16'd0, 16'd10, 1'b0, 8'h00);
      // A reset in mid-run clears the response and empties the table, so slot 1 stops matching.
      @(negedge ref_clk);
      rst_n = 1'b0;
      @(negedge ref_clk);
      chk_rsp(29'h0);
      rst_n = 1'b1;
      pk(8'h13, 8'h11, 32'h0a010203, 32'h0, 16'd0, 16'd1000, 1'b0, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
